// File: rtl/path_switch_defines.vh
// constants for the antenna path switch serial slave and register bank
`ifndef PATH_SWITCH_DEFINES_VH
`define PATH_SWITCH_DEFINES_VH
// register addresses (5 bits)
`define ADDR_PATH_SELECT 5'h00
`define ADDR_STATUS 5'h1a
`define ADDR_GROUP_SLAVE 5'h1b
`define ADDR_POWER_TRIG 5'h1c
`define ADDR_PRODUCT_IDENTITY 5'h1d
`define ADDR_MAKER_LOW 5'h1e
`define ADDR_MAKER_HIGH 5'h1f
// reset values
`define RST_PATH_SELECT 8'h00
`define RST_STATUS 8'h00
`define RST_GROUP_SLAVE 4'h0
`define RST_POWER_TRIG 8'h00
`define RST_UNIQUE_SLAVE 4'hb
// power state field encodings
`define PWR_ACTIVE 2'h0
`define PWR_STARTUP 2'h1
`define PWR_LOW 2'h2
`define PWR_DISCARD 2'h3
// path select encodings
`define SEL_PORT_ONE 8'h06
`define SEL_PORT_TWO 8'h05
`define SEL_PORT_THREE 8'h07
`define SEL_PORT_FOUR 8'h03
`define SEL_PORT_FIVE 8'h09
`define SEL_PORT_SIX 8'h01
`define SEL_SLEEP 8'h00
`define SEL_ISOLATE 8'h7f
// command frame codes (top 3 bits of the 8-bit command after the slave address)
`define CMD_REG_WRITE 3'h2
`define CMD_REG_READ 3'h3
// timing
`define STARTUP_TIME_NS 20000
`define CLK_PERIOD_NS 5
`endif

// File: rtl/path_decoder.v
// decodes a path select byte into one-hot RF port controls
`timescale 1ns/10ps
`default_nettype none
`include "path_switch_defines.vh"
module path_decoder (
    input wire [7:0] sel,
    output reg [7:0] ports,
    output reg valid
);
    // bits 0..5 ports one..six, bit 6 sleep, bit 7 isolation
    // byte codes to selections
    always @* begin
        valid = 1'b1;
        case (sel)
            `SEL_PORT_ONE: ports = 8'h01;
            `SEL_PORT_TWO: ports = 8'h02;
            `SEL_PORT_THREE: ports = 8'h04;
            `SEL_PORT_FOUR: ports = 8'h08;
            `SEL_PORT_FIVE: ports = 8'h10;
            `SEL_PORT_SIX: ports = 8'h20;
            `SEL_SLEEP: ports = 8'h40;
            `SEL_ISOLATE: ports = 8'h80;
            default: begin
                ports = 8'h80;
                valid = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// File: rtl/path_switch_slave.v
// serial slave, register bank and power state logic of the antenna path switch
//
// Functional notes
// - input data sampled on falling bus clock
// - read data launched on rising bus clock
// - active state reached within 20 us of reset; a startup write ends in low power
// - fixed register address map
// - status register resets zero, read/write
// - power field 7:6, trigger field 5:0
// - path select byte decodes eight selections
// - power writes: active, startup, low, discard
// - disable bits 5:3, load bits 2:0
// - startup restores defaults; RF path active-only
`timescale 1ns/10ps
`default_nettype none
`include "path_switch_defines.vh"
module path_switch_slave #(
    parameter [7:0] PRODUCT_IDENTITY = 8'h5a, // arbitrary value
    parameter [7:0] MAKER_LOW = 8'h3c, // arbitrary value
    parameter [1:0] MAKER_HIGH = 2'h2, // arbitrary value
    parameter STARTUP_CYCLES = `STARTUP_TIME_NS / `CLK_PERIOD_NS
) (
    input wire REF_CLK,
    input wire SRST,
    input wire SCLK,
    input wire SDATA_IN,
    output reg SDATA_OUT,
    output reg SDATA_OE,
    output reg [7:0] RF_PORTS,
    output reg ACTIVE,
    output reg [1:0] POWER_STATE
);
    // ------------------------------------------------------------
    // input synchronisers and edge detect
    // ------------------------------------------------------------
    reg sclk_m_q, sclk_s_q, sclk_d_q, sda_m_q, sda_s_q;
    always @(posedge REF_CLK) begin
        sclk_m_q <= SCLK;
        sclk_s_q <= sclk_m_q;
        sclk_d_q <= sclk_s_q;
        sda_m_q <= SDATA_IN;
        sda_s_q <= sda_m_q;
    end
    wire sclk_rise = sclk_s_q & ~sclk_d_q;
    wire sclk_fall = ~sclk_s_q & sclk_d_q;

    // ------------------------------------------------------------
    // frame state machine
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_CMD = 3'd1;
    localparam [2:0] ST_WDATA = 3'd2;
    localparam [2:0] ST_PARK = 3'd3;
    localparam [2:0] ST_RDATA = 3'd4;
    localparam [2:0] ST_END = 3'd5;
    reg [2:0] st_q;
    reg [3:0] cnt_q;
    reg [12:0] cmd_q;
    reg [8:0] data_q;
    reg [8:0] shout_q;
    reg sda_prev_q;

    // register bank
    reg [7:0] path_q, status_q, pwr_q;
    reg [3:0] gsa_q;
    reg [7:0] held_ports_q;
    reg [1:0] pstate_q;
    reg [15:0] su_cnt_q;

    wire [7:0] dec_ports;
    wire dec_valid;
    path_decoder u_dec (
        .sel(path_q),
        .ports(dec_ports),
        .valid(dec_valid)
    );

    // odd parity check: high when the word, parity bit included, holds an odd count of ones
    function par13;
        input [12:0] v;
        begin
            par13 = ^v;
        end
    endfunction

    // read mux
    function [7:0] rd_mux;
        input [4:0] a;
        input [7:0] p, s, pw;
        input [3:0] g;
        begin
            case (a)
                `ADDR_PATH_SELECT: rd_mux = p;
                `ADDR_STATUS: rd_mux = s;
                `ADDR_GROUP_SLAVE: rd_mux = {4'h0, g};
                `ADDR_POWER_TRIG: rd_mux = pw;
                `ADDR_PRODUCT_IDENTITY: rd_mux = PRODUCT_IDENTITY;
                `ADDR_MAKER_LOW: rd_mux = MAKER_LOW;
                `ADDR_MAKER_HIGH: rd_mux = {2'h0, MAKER_HIGH, `RST_UNIQUE_SLAVE};
                default: rd_mux = 8'h00;
            endcase
        end
    endfunction

    // command word including the bit taken on the current falling edge
    wire [12:0] cmd_nxt = {cmd_q[11:0], sda_s_q};
    wire [2:0] nxt_op = cmd_nxt[8:6];
    wire [3:0] f_sa = cmd_q[12:9];
    wire [4:0] f_addr = cmd_q[5:1];
    wire addr_hit = (f_sa == `RST_UNIQUE_SLAVE) || (f_sa == gsa_q);
    wire wr_go = (st_q == ST_WDATA) && sclk_fall && (cnt_q == 4'd8);
    // data word including the parity bit that arrives on the last edge
    wire [8:0] wword = {data_q[7:0], sda_s_q};
    wire wr_ok = wr_go && addr_hit && par13({4'h0, wword});
    wire [7:0] wdata = wword[8:1];
    // read-back byte of the addressed register
    wire [7:0] rd_byte = rd_mux(f_addr, path_q, status_q, pwr_q, gsa_q);
    wire startup_req = wr_ok && (f_addr == `ADDR_POWER_TRIG) && (wdata[7:6] == `PWR_STARTUP);
    // sequence start: data rises while clock low
    wire ssc = (st_q == ST_IDLE) && ~sclk_s_q && sda_s_q && ~sda_prev_q;

    // ------------------------------------------------------------
    // serial frame receiver and transmitter
    // ------------------------------------------------------------
    always @(posedge REF_CLK) begin
        sda_prev_q <= sda_s_q;
        if (SRST) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'd0;
            cmd_q <= 13'h0000;
            data_q <= 9'h000;
            shout_q <= 9'h000;
            SDATA_OUT <= 1'b0;
            SDATA_OE <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    cnt_q <= 4'd0;
                    if (ssc)
                        st_q <= ST_CMD;
                end
                ST_CMD: if (sclk_fall) begin
                    cmd_q <= cmd_nxt;
                    cnt_q <= cnt_q + 4'd1;
                    if (cnt_q == 4'd12) begin
                        cnt_q <= 4'd0;
                        if (!par13(cmd_nxt) ||
                            (nxt_op != `CMD_REG_WRITE && nxt_op != `CMD_REG_READ))
                            st_q <= ST_IDLE;
                        else if (nxt_op == `CMD_REG_READ)
                            st_q <= ST_PARK;
                        else
                            st_q <= ST_WDATA;
                    end
                end
                ST_WDATA: if (sclk_fall) begin
                    data_q <= {data_q[7:0], sda_s_q};
                    cnt_q <= cnt_q + 4'd1;
                    if (cnt_q == 4'd8)
                        st_q <= ST_END;
                end
                ST_PARK: if (sclk_rise) begin
                    // bus park cycle, then drive read data
                    if (addr_hit) begin
                        shout_q <= {rd_byte, ~^rd_byte};
                        st_q <= ST_RDATA;
                    end else
                        st_q <= ST_IDLE;
                end
                ST_RDATA: if (sclk_rise) begin
                    SDATA_OE <= 1'b1;
                    SDATA_OUT <= shout_q[8];
                    shout_q <= {shout_q[7:0], 1'b0};
                    cnt_q <= cnt_q + 4'd1;
                    if (cnt_q == 4'd9) begin
                        SDATA_OUT <= 1'b0;
                        st_q <= ST_END;
                    end
                end
                ST_END: if (sclk_fall) begin
                    SDATA_OE <= 1'b0;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register bank and power state
    // ------------------------------------------------------------
    always @(posedge REF_CLK) begin
        if (SRST || startup_req) begin
            path_q <= `RST_PATH_SELECT;
            status_q <= `RST_STATUS;
            gsa_q <= `RST_GROUP_SLAVE;
            pwr_q <= `RST_POWER_TRIG;
            held_ports_q <= 8'h40;
            pstate_q <= SRST ? `PWR_STARTUP : `PWR_LOW;
            su_cnt_q <= 16'h0000;
        end else begin
            if (pstate_q == `PWR_STARTUP) begin
                su_cnt_q <= su_cnt_q + 16'h0001;
                if (su_cnt_q == STARTUP_CYCLES[15:0] - 16'h0001)
                    pstate_q <= `PWR_ACTIVE;
            end
            if (dec_valid)
                held_ports_q <= dec_ports;
            if (wr_ok) begin
                case (f_addr)
                    `ADDR_PATH_SELECT: path_q <= wdata;
                    `ADDR_STATUS: status_q <= wdata;
                    `ADDR_GROUP_SLAVE: gsa_q <= wdata[3:0];
                    `ADDR_POWER_TRIG: begin
                        if (wdata[7:6] != `PWR_DISCARD) begin
                            pwr_q[7:6] <= wdata[7:6];
                            pstate_q <= wdata[7:6];
                        end
                        // disable bits kept, load bits write-only
                        pwr_q[5:3] <= wdata[5:3];
                        pwr_q[2:0] <= 3'h0;
                    end
                    default: status_q[1] <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always @(posedge REF_CLK) begin
        if (SRST) begin
            RF_PORTS <= 8'h00;
            ACTIVE <= 1'b0;
            POWER_STATE <= `PWR_STARTUP;
        end else begin
            // RF path driven only when active
            RF_PORTS <= (pstate_q == `PWR_ACTIVE) ? held_ports_q : 8'h00;
            ACTIVE <= (pstate_q == `PWR_ACTIVE);
            POWER_STATE <= pstate_q;
        end
    end
endmodule
`default_nettype wire

// File: verif/path_switch_checks_asserts.sv
// port checker of the path switch serial slave
`timescale 1ns/10ps
`default_nettype none
module path_switch_checks #(
    parameter STARTUP_CYCLES = 20
) (
    input wire REF_CLK,
    input wire SRST,
    input wire SCLK,
    input wire SDATA_IN,
    input wire SDATA_OUT,
    input wire SDATA_OE,
    input wire [7:0] RF_PORTS,
    input wire ACTIVE,
    input wire [1:0] POWER_STATE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    int st_cnt_q;
    // counts cycles spent in startup
    always @(posedge REF_CLK) begin
        st_cnt_q <= (SRST || POWER_STATE != 2'h1) ? 0 : st_cnt_q + 1;
    end
    a_ports_one_hot: assert property ($onehot0(RF_PORTS))
        else $error("ports not one-hot");
    a_ports_idle_off: assert property (!ACTIVE |-> RF_PORTS == 8'h00)
        else $error("ports on while inactive");
    a_active_match: assert property (ACTIVE == (POWER_STATE == 2'h0))
        else $error("active flag wrong");
    a_startup_bound: assert property (st_cnt_q <= STARTUP_CYCLES + 4)
        else $error("startup too long");
    a_reset_startup: assert property ($fell(SRST) |-> POWER_STATE == 2'h1 && !SDATA_OE)
        else $error("no startup after reset");
    a_launch_rise: assert property (SDATA_OE && $changed(SDATA_OUT) |-> $past(SCLK, 2))
        else $error("read bit not after rise");
    a_release_fall: assert property ($fell(SDATA_OE) |-> !$past(SCLK, 2))
        else $error("release not after fall");
    a_capture_fall: assert property (ACTIVE && $past(ACTIVE) && $changed(RF_PORTS)
        |-> !$past(SCLK, 2))
        else $error("write not after fall");
    c_read: cover property ($rose(SDATA_OE));
    c_low_power: cover property (POWER_STATE == 2'h2);
    c_isolate: cover property (RF_PORTS == 8'h80);
endmodule
`default_nettype wire

// File: verif/bus_master_model.sv
// serial bus master model issuing register frames
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
    output logic sclk,
    output logic sdo,
    output logic sdo_en,
    input wire logic sdata,
    output logic rd_done,
    output logic [8:0] rd_word
);
    logic [10:0] sh;
    // idle: clock parked low, data held low
    initial begin
        sclk = 1'b0;
        sdo = 1'b0;
        sdo_en = 1'b1;
        rd_done = 1'b0;
        rd_word = 9'h000;
        sh = 11'h000;
    end
    // set on rise, taken at fall
    task automatic clk_bit(input logic b);
        sclk = 1'b1;
        sdo = b;
        #24;
        sh = {sh[9:0], sdata};
        sclk = 1'b0;
        #24;
    endtask
    // 96 ns trailing gap added here; order kept by caller
    task automatic frame(input logic [4:0] a, input logic rd, input logic [8:0] wd);
        logic [11:0] cmd;
        cmd = {4'hb, 2'b01, rd, a};
        sdo = 1'b1;
        #24;
        sdo = 1'b0;
        #24;
        for (int i = 11; i >= 0; i--) clk_bit(cmd[i]);
        clk_bit(~^cmd);
        sdo_en = !rd;
        for (int i = 8; i >= 0; i--) clk_bit(rd ? 1'b0 : wd[i]);
        clk_bit(1'b0);
        if (rd) begin
            clk_bit(1'b0);
            sdo_en = 1'b1;
            rd_word = sh[9:1];
            rd_done = 1'b1;
            #1 rd_done = 1'b0;
        end
        #96;
    endtask
endmodule
`default_nettype wire

// File: verif/rf_path_switch_slave_regs_tb.sv
// self-checking bench of the path switch slave
`timescale 1ns/10ps
`default_nettype none
module rf_path_switch_slave_regs_tb;
    localparam int STARTUP_CYCLES = 20;
    localparam logic [7:0] PID = 8'h93; // arbitrary value
    localparam logic [7:0] MLO = 8'h4e; // arbitrary value
    localparam logic [1:0] MHI = 2'h2; // arbitrary value
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic pt_v = 1'b0;
    logic float_q = 1'b0;
    logic [31:0] seed = 32'h0000_0050;
    wire logic sclk, m_do, m_en, sdata_w, sdata_out, sdata_oe, active, rd_done;
    wire logic [7:0] rf_ports;
    wire logic [1:0] power_state;
    wire logic [8:0] rd_word;
    logic [10:0] rd_q[$], pt_q[$];
    logic [7:0] r, g;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    logic [4:0] ra[6] = '{5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
    logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h00, PID, MLO, {2'b00, MHI, 4'hb}};
    // unknown code 02 follows port six, so holding differs from isolation
    logic [7:0] pc[9] = '{8'h06, 8'h05, 8'h07, 8'h03, 8'h09, 8'h01, 8'h02, 8'h00, 8'h7f};
    logic [7:0] pe[9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h20, 8'h40, 8'h80};
    logic [7:0] pw[4] = '{8'hf8, 8'hb8, 8'h78, 8'h38};
    logic [10:0] ps[4] = '{11'h480, 11'h200, 11'h200, 11'h440};
    // undriven wire shows a changing pattern
    assign sdata_w = sdata_oe ? sdata_out : (m_en ? m_do : float_q);
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    path_switch_slave #(.PRODUCT_IDENTITY(PID), .MAKER_LOW(MLO), .MAKER_HIGH(MHI),
        .STARTUP_CYCLES(STARTUP_CYCLES)) dut (.REF_CLK(ref_clk), .SRST(srst), .SCLK(sclk),
        .SDATA_IN(sdata_w), .SDATA_OUT(sdata_out), .SDATA_OE(sdata_oe), .RF_PORTS(rf_ports),
        .ACTIVE(active), .POWER_STATE(power_state));
    bus_master_model m (.sclk(sclk), .sdo(m_do), .sdo_en(m_en), .sdata(sdata_w),
        .rd_done(rd_done), .rd_word(rd_word));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic compare(input string what, input logic [10:0] e, input logic [10:0] s);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic bad = 1'b0);
        m.frame(a, 1'b0, {d, ~^d ^ bad});
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        rd_q.push_back({2'b00, e, ~^e});
        m.frame(a, 1'b1, 9'h000);
    endtask
    task automatic snap(input logic [10:0] e);
        pt_q.push_back(e);
        @(negedge ref_clk) pt_v = 1'b1;
        @(negedge ref_clk) pt_v = 1'b0;
    endtask
    // result watchers take the oldest note
    always @(posedge rd_done) compare("read", rd_q.pop_front(), {2'b00, rd_word});
    always @(posedge pt_v)
        compare("state", pt_q.pop_front(), {active, power_state, rf_ports});
    always @(posedge ref_clk) float_q <= ~float_q;
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        srst = 1'b0;
        snap(11'h100);
        repeat (STARTUP_CYCLES + 8) @(negedge ref_clk);
        snap(11'h440);
        for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
        r = 8'(xs()) & 8'h7d;
        g = 8'(xs()) & 8'h0f;
        wr(5'h1a, r);
        wr(5'h1b, g);
        rd(5'h1a, r);
        rd(5'h1b, g);
        wr(5'h1c, 8'h3f);
        rd(5'h1c, 8'h38);
        // broken data parity is dropped
        wr(5'h1b, g ^ 8'h05, 1'b1);
        rd(5'h1b, g);
        wr(5'h1d, ~PID);
        rd(5'h1d, PID);
        rd(5'h1a, r | 8'h02);
        wr(5'h1c, 8'h38);
        for (int i = 0; i < 9; i++) begin
            wr(5'h00, pc[i]);
            snap({3'b100, pe[i]});
            rd(5'h00, pc[i]);
            #20000;
        end
        for (int i = 0; i < 4; i++) begin
            wr(5'h1c, pw[i]);
            #((STARTUP_CYCLES + 8) * 5);
            snap(ps[i]);
        end
        rd(5'h1a, 8'h00);
        report_and_stop();
    end
endmodule
bind path_switch_slave path_switch_checks #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (
    .REF_CLK(REF_CLK), .SRST(SRST), .SCLK(SCLK), .SDATA_IN(SDATA_IN), .SDATA_OUT(SDATA_OUT),
    .SDATA_OE(SDATA_OE), .RF_PORTS(RF_PORTS), .ACTIVE(ACTIVE), .POWER_STATE(POWER_STATE));
`default_nettype wire
